// File: verilog/dsrap_defs.svh
// Constants of the dual serial register access port.
// What this block does
// R1 - Both serial ports run only from host serial clock edges, no internal bit clock.
// R2 - Accesses are accepted only after power-on reset release, about 2 to 6 us.
// R3 - Register addresses are 15 bits; one address is reserved for FIFO reads.
// R4 - Address advances by one per further word in the same access, reads and writes.
// R5 - No address advance at the FIFO address, the one below it, or 0x277.
// R6 - Each read at the FIFO address returns the next FIFO byte.
// R7 - SPI starts with a two-byte header of address and direction, then 16-bit words.
// R8 - SPI writes commit only complete 16-bit words before chip select rises.
// R9 - Further SPI write words while selected go to following registers.
// R10 - SPI read data leaves MSB first, continuing to following registers.
// R11 - Host reads the FIFO bytewise; device never needs whole words there.
// R12 - I2C side is slave only and drives data open drain in its own bit times.
// R13 - First register address bit selects 7-bit (0) or 15-bit (1) address.
// R14 - Host uses short addresses only for registers at 0x007F or below.
// R15 - Device acknowledges slave address, register address and every written byte.
// R16 - I2C writes commit after both bytes before stop, then the address advances.
// R17 - I2C read: address write, restart with read, device acks and sends bytes.
// R18 - Repeated I2C data bytes follow the same address advance rules.
// R19 - SPI header holds the address in bits 15..1 and write-high in bit 0.
`ifndef DSRAP_DEFS_SVH
`define DSRAP_DEFS_SVH

`define ADDR_W         15
`define DATA_W         16
`define FIFO_ADDR      15'h0030
`define LAST_ADDR      15'h0277
`define I2C_DEV_ADDR   7'h24
`define SPI_WR_BIT     0
`define CLK_PERIOD_NS  5
`define POR_MIN_NS     2000
`define POR_CYCLES     ((`POR_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POR_CNT_W      9
`define SYNC_W         5
`define SYNC_INIT      5'h1e
`define SY_SCLK        0
`define SY_CS          1
`define SY_MOSI        2
`define SY_SCL         3
`define SY_SDA         4

`endif

// File: verilog/dsrap_pkg.sv
// State types of the dual serial register access port.
`default_nettype none
package dsrap_pkg;
    typedef enum logic [1:0] {S_HDR, S_WR, S_RD} spi_st_e;
    typedef enum logic [2:0] {I_IDLE, I_DEV, I_REG_HI, I_REG_LO, I_WR, I_RD, I_WAIT} i2c_st_e;
endpackage
`default_nettype wire

// File: verilog/pin_sync.sv
// Two-flop synchroniser with a third stage for edge detection.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk,   // System clock.
    input  wire logic         rst_b, // Asynchronous reset, active low.
    input  wire logic [W-1:0] d,     // Asynchronous inputs.
    output logic      [W-1:0] q,     // Synchronised levels.
    output logic      [W-1:0] q_d    // Synchronised levels one cycle older.
);
    logic [W-1:0] meta_r;

    // Each bit passes two flops; the first is read only by the second.
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                meta_r[i] <= INIT[i];
                q[i]      <= INIT[i];
                q_d[i]    <= INIT[i];
            end else begin
                meta_r[i] <= d[i];
                q[i]      <= meta_r[i];
                q_d[i]    <= q[i];
            end
        end
    end
endmodule
`default_nettype wire

// File: verilog/dual_serial_register_access_port.sv
// SPI and I2C slave ports giving a host access to 16-bit registers.
`timescale 1ns/100ps
`default_nettype none
`include "dsrap_defs.svh"
module dual_serial_register_access_port (
    input  wire logic                 sys_clk,   // System clock, 200 MHz.
    input  wire logic                 rst_b,     // Asynchronous reset, active low.
    input  wire logic                 sclk,      // SPI serial clock pin.
    input  wire logic                 spi_cs_b,  // SPI chip select pin, active low.
    input  wire logic                 mosi,      // SPI data from host.
    output logic                      miso,      // SPI data to host.
    output logic                      miso_oe,   // High while selected.
    input  wire logic                 scl,       // I2C clock pin.
    input  wire logic                 sda_in,    // I2C data pin level.
    output logic                      sda_out,   // I2C data drive value, always low.
    output logic                      sda_oe,    // High while pulling data low.
    output logic [`ADDR_W-1:0]        reg_addr,  // Register address.
    output logic [`DATA_W-1:0]        reg_wdata, // Register write data.
    output logic                      reg_wr,    // Write strobe.
    output logic                      reg_rd,    // Read strobe; pops FIFO at its address.
    input  wire logic [`DATA_W-1:0]   reg_rdata  // Read data, valid the cycle after reg_rd.
);
    logic [`SYNC_W-1:0]    sq;
    logic [`SYNC_W-1:0]    sqd;
    logic [`POR_CNT_W-1:0] por_cnt_r;
    logic                  por_done_r;
    dsrap_pkg::spi_st_e    spi_st_r;
    logic [3:0]            spi_cnt_r;
    logic [15:0]           spi_sh_r;
    logic [14:0]           spi_addr_r;
    logic [15:0]           spi_tx_r;
    logic [1:0]            spi_load_r;
    logic                  miso_r;
    logic                  miso_oe_r;
    dsrap_pkg::i2c_st_e    i2c_st_r;
    logic [3:0]            i_cnt_r;
    logic [7:0]            i_sh_r;
    logic                  i_ackph_r;
    logic [14:0]           i_addr_r;
    logic [7:0]            i_hi_r;
    logic                  i_have_hi_r;
    logic                  i_first_r;
    logic                  i_second_r;
    logic                  i_mack_r;
    logic [7:0]            i_tx_r;
    logic [15:0]           i_word_r;
    logic [1:0]            i_load_r;
    logic                  sda_oe_r;
    logic [14:0]           reg_addr_r;
    logic [15:0]           reg_wdata_r;
    logic                  reg_wr_r;
    logic                  reg_rd_r;

    // Address advance, held at the FIFO, just below it and at the last address.
    function automatic logic [14:0] next_addr(input logic [14:0] a);
        if (a == `FIFO_ADDR || a == `FIFO_ADDR - 15'h1 || a == `LAST_ADDR) begin // [R5]
            return a;
        end
        return a + 15'h1; // [R4]
    endfunction

    // All pins are asynchronous and pass two flops before use.
    pin_sync #(.W(`SYNC_W), .INIT(`SYNC_INIT)) u_sync (
        .clk   (sys_clk),
        .rst_b (rst_b),
        .d     ({sda_in, scl, mosi, spi_cs_b, sclk}),
        .q     (sq),
        .q_d   (sqd)
    );

    // Edges of the host clocks drive all bit activity.
    wire sclk_rise = sq[`SY_SCLK] & ~sqd[`SY_SCLK]; // [R1]
    wire sclk_fall = ~sq[`SY_SCLK] & sqd[`SY_SCLK];
    wire cs_act    = ~sq[`SY_CS];
    wire mosi_s    = sq[`SY_MOSI];
    wire scl_rise  = sq[`SY_SCL] & ~sqd[`SY_SCL];
    wire scl_fall  = ~sq[`SY_SCL] & sqd[`SY_SCL];
    wire scl_high  = sq[`SY_SCL] & sqd[`SY_SCL];
    wire sda_s     = sq[`SY_SDA];
    wire i2c_start = por_done_r & scl_high & ~sq[`SY_SDA] & sqd[`SY_SDA];
    wire i2c_stop  = por_done_r & scl_high & sq[`SY_SDA] & ~sqd[`SY_SDA];

    // Power-on hold-off: the ports stay deaf until the count has run.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            por_cnt_r  <= '0;
            por_done_r <= 1'b0;
        end else if (!por_done_r) begin
            if (por_cnt_r == `POR_CNT_W'(`POR_CYCLES - 1)) begin
                por_done_r <= 1'b1; // [R2]
            end else begin
                por_cnt_r <= por_cnt_r + `POR_CNT_W'(1);
            end
        end
    end

    // SPI word framing: header, then 16-bit words, FIFO reads 8 bits.
    wire        spi_bit     = por_done_r & cs_act & sclk_rise;
    wire [15:0] spi_word_in = {spi_sh_r[14:0], mosi_s};
    wire        spi_fifo    = (spi_addr_r == `FIFO_ADDR); // [R3]
    wire [3:0]  spi_last    = (spi_st_r == dsrap_pkg::S_RD && spi_fifo) ? 4'h7 : 4'hf; // [R11]
    wire        spi_end     = spi_bit & (spi_cnt_r == spi_last);
    wire        spi_hdr_go  = spi_end & (spi_st_r == dsrap_pkg::S_HDR); // [R7]
    wire        spi_wr_go   = spi_end & (spi_st_r == dsrap_pkg::S_WR); // [R8]
    wire        spi_rd_adv  = spi_end & (spi_st_r == dsrap_pkg::S_RD);
    wire        spi_rd_req  = (spi_hdr_go & ~spi_word_in[`SPI_WR_BIT]) | spi_rd_adv;
    wire [14:0] spi_rd_addr = spi_hdr_go ? spi_word_in[15:1] : next_addr(spi_addr_r);

    // SPI receive side; releasing chip select drops any partial word.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            spi_st_r   <= dsrap_pkg::S_HDR;
            spi_cnt_r  <= '0;
            spi_sh_r   <= '0;
            spi_addr_r <= '0;
        end else if (!cs_act) begin
            spi_st_r  <= dsrap_pkg::S_HDR; // [R8]
            spi_cnt_r <= '0;
        end else if (spi_bit) begin
            spi_sh_r  <= spi_word_in;
            spi_cnt_r <= spi_end ? 4'h0 : spi_cnt_r + 4'h1;
            if (spi_hdr_go) begin
                spi_addr_r <= spi_word_in[15:1]; // [R19]
                spi_st_r   <= spi_word_in[`SPI_WR_BIT] ? dsrap_pkg::S_WR : dsrap_pkg::S_RD;
            end else if (spi_wr_go || spi_rd_adv) begin
                spi_addr_r <= next_addr(spi_addr_r); // [R9] [R4]
            end
        end
    end

    // SPI transmit side: read data arrives the cycle after the strobe, so it is loaded two cycles
    // after the request; each fall then presents the top bit and shifts, so the MSB is not skipped.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            spi_load_r <= 2'h0;
            spi_tx_r   <= '0;
            miso_r     <= 1'b0;
            miso_oe_r  <= 1'b0;
        end else begin
            spi_load_r <= {spi_load_r[0], spi_rd_req};
            miso_oe_r  <= cs_act;
            if (spi_load_r[1]) begin
                spi_tx_r <= spi_fifo ? {reg_rdata[7:0], 8'h00} : reg_rdata; // [R6]
                miso_r   <= spi_fifo ? reg_rdata[7] : reg_rdata[15]; // [R10]
            end else if (cs_act && sclk_fall && spi_st_r == dsrap_pkg::S_RD) begin
                spi_tx_r <= {spi_tx_r[14:0], 1'b0};
                miso_r   <= spi_tx_r[15]; // [R10]
            end
        end
    end

    // I2C byte framing: eight data bits, then one acknowledge bit.
    wire        i_live      = (i2c_st_r != dsrap_pkg::I_IDLE) && (i2c_st_r != dsrap_pkg::I_WAIT);
    wire        i_rise      = por_done_r & i_live & scl_rise;
    wire        i_fall      = por_done_r & i_live & scl_fall;
    wire        i_byte_end  = i_fall & ~i_ackph_r & (i_cnt_r == 4'h8);
    wire        i_ack_end   = i_fall & i_ackph_r;
    wire        i_match     = (i_sh_r[7:1] == `I2C_DEV_ADDR);
    wire        i_fifo      = (i_addr_r == `FIFO_ADDR);
    wire        i_rcv_state = (i2c_st_r == dsrap_pkg::I_REG_HI) || (i2c_st_r == dsrap_pkg::I_REG_LO)
                              || (i2c_st_r == dsrap_pkg::I_WR);
    wire        i_ack_drive = i_byte_end & (((i2c_st_r == dsrap_pkg::I_DEV) & i_match) | i_rcv_state);
    wire        i_wr_go     = i_byte_end & (i2c_st_r == dsrap_pkg::I_WR) & i_have_hi_r; // [R16]
    wire        i_rd_first  = i_byte_end & (i2c_st_r == dsrap_pkg::I_DEV) & i_match & i_sh_r[0];
    wire        i_rd_adv    = i_rise & i_ackph_r & ~i_first_r & (i2c_st_r == dsrap_pkg::I_RD)
                              & ~sda_s & (i_fifo | i_second_r); // [R18]
    wire        i_rd_req    = i_rd_first | i_rd_adv;
    wire [14:0] i_rd_addr   = i_rd_first ? i_addr_r : next_addr(i_addr_r);
    wire        i_next_lo   = ~i_first_r & ~i_second_r & ~i_fifo;
    wire [7:0]  i_sel_byte  = (i_next_lo | i_fifo) ? i_word_r[7:0] : i_word_r[15:8]; // [R6]

    // I2C slave protocol engine; a restart keeps the register address.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            i2c_st_r    <= dsrap_pkg::I_IDLE;
            i_cnt_r     <= '0;
            i_sh_r      <= '0;
            i_ackph_r   <= 1'b0;
            i_addr_r    <= '0;
            i_hi_r      <= '0;
            i_have_hi_r <= 1'b0;
            i_first_r   <= 1'b0;
            i_second_r  <= 1'b0;
            i_mack_r    <= 1'b0;
        end else if (i2c_start || i2c_stop) begin
            i2c_st_r    <= i2c_start ? dsrap_pkg::I_DEV : dsrap_pkg::I_IDLE; // [R12]
            i_cnt_r     <= '0;
            i_ackph_r   <= 1'b0;
            i_have_hi_r <= 1'b0; // [R16]
            i_first_r   <= 1'b0;
            i_second_r  <= 1'b0;
        end else begin
            if (i_rise && !i_ackph_r && i_cnt_r != 4'h8) begin
                i_sh_r  <= {i_sh_r[6:0], sda_s};
                i_cnt_r <= i_cnt_r + 4'h1;
            end
            if (i_rise && i_ackph_r) begin
                i_mack_r <= ~sda_s;
            end
            if (i_rd_adv) begin
                i_addr_r <= next_addr(i_addr_r); // [R18]
            end
            if (i_byte_end) begin
                i_ackph_r <= 1'b1;
                unique case (i2c_st_r)
                    dsrap_pkg::I_DEV: begin
                        i2c_st_r  <= !i_match ? dsrap_pkg::I_WAIT
                                   : (i_sh_r[0] ? dsrap_pkg::I_RD : dsrap_pkg::I_REG_HI); // [R17]
                        i_first_r <= i_match & i_sh_r[0];
                    end
                    dsrap_pkg::I_REG_HI: begin
                        if (i_sh_r[7]) begin
                            i_addr_r[14:8] <= i_sh_r[6:0]; // [R13]
                            i2c_st_r       <= dsrap_pkg::I_REG_LO;
                        end else begin
                            i_addr_r <= {8'h00, i_sh_r[6:0]}; // [R13] [R14]
                            i2c_st_r <= dsrap_pkg::I_WR;
                        end
                    end
                    dsrap_pkg::I_REG_LO: begin
                        i_addr_r[7:0] <= i_sh_r;
                        i2c_st_r      <= dsrap_pkg::I_WR;
                    end
                    dsrap_pkg::I_WR: begin
                        i_hi_r      <= i_sh_r;
                        i_have_hi_r <= ~i_have_hi_r;
                        if (i_have_hi_r) begin
                            i_addr_r <= next_addr(i_addr_r); // [R16] [R4]
                        end
                    end
                    dsrap_pkg::I_RD: begin
                        i_have_hi_r <= 1'b0;
                    end
                    default: begin
                        i2c_st_r <= dsrap_pkg::I_WAIT;
                    end
                endcase
            end
            if (i_ack_end) begin
                i_ackph_r <= 1'b0;
                i_cnt_r   <= '0;
                i_first_r <= 1'b0;
                if (i2c_st_r == dsrap_pkg::I_RD) begin
                    i_second_r <= i_next_lo;
                    if (!i_first_r && !i_mack_r) begin
                        i2c_st_r <= dsrap_pkg::I_WAIT; // [R17]
                    end
                end
            end
        end
    end

    // I2C data drive: acknowledges and read bits, open drain low only.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sda_oe_r <= 1'b0;
            i_tx_r   <= '0;
            i_load_r <= 2'h0;
            i_word_r <= '0;
        end else begin
            i_load_r <= {i_load_r[0], i_rd_req}; // Read data stands the cycle after the strobe.
            if (i_load_r[1]) begin
                i_word_r <= reg_rdata;
            end
            if (i2c_start || i2c_stop) begin
                sda_oe_r <= 1'b0; // [R12]
            end else if (i_byte_end) begin
                sda_oe_r <= i_ack_drive; // [R15]
            end else if (i_ack_end) begin
                if (i2c_st_r == dsrap_pkg::I_RD && (i_first_r || i_mack_r)) begin
                    i_tx_r   <= i_sel_byte;
                    sda_oe_r <= ~i_sel_byte[7]; // [R17]
                end else begin
                    sda_oe_r <= 1'b0;
                end
            end else if (i_fall && !i_ackph_r && i2c_st_r == dsrap_pkg::I_RD) begin
                i_tx_r   <= {i_tx_r[6:0], 1'b0};
                sda_oe_r <= ~i_tx_r[6];
            end
        end
    end

    // Shared register strobes; a write wins over a read, and SPI wins if both ports ask for the same kind at once.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_addr_r  <= '0;
            reg_wdata_r <= '0;
            reg_wr_r    <= 1'b0;
            reg_rd_r    <= 1'b0;
        end else begin
            reg_wr_r <= spi_wr_go | i_wr_go;
            reg_rd_r <= spi_rd_req | i_rd_req;
            if (spi_wr_go) begin
                reg_addr_r  <= spi_addr_r;
                reg_wdata_r <= spi_word_in; // [R8]
            end else if (i_wr_go) begin
                reg_addr_r  <= i_addr_r;
                reg_wdata_r <= {i_hi_r, i_sh_r}; // [R16]
            end else if (spi_rd_req) begin
                reg_addr_r <= spi_rd_addr;
            end else if (i_rd_req) begin
                reg_addr_r <= i_rd_addr;
            end
        end
    end

    assign miso      = miso_r;
    assign miso_oe   = miso_oe_r;
    assign sda_out   = 1'b0;
    assign sda_oe    = sda_oe_r;
    assign reg_addr  = reg_addr_r;
    assign reg_wdata = reg_wdata_r;
    assign reg_wr    = reg_wr_r;
    assign reg_rd    = reg_rd_r;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_spi_fetch;
        reg_rd && spi_load_r[0] && reg_addr == spi_addr_r;
    endsequence

    sequence s_i2c_commit;
        reg_wr && reg_wdata == $past({i_hi_r, i_sh_r});
    endsequence

    AST_POR_QUIET: assert property (!por_done_r |=> !reg_wr && !reg_rd) // [R2]
        else $error("Register strobe before power-on hold-off ended.");
    AST_POR_TIME: assert property ($rose(por_done_r) |-> por_cnt_r == `POR_CNT_W'(`POR_CYCLES - 1)) // [R2]
        else $error("Power-on hold-off ended at the wrong count.");
    AST_NO_CLK_NO_SHIFT: assert property (!spi_bit |=> $stable(spi_sh_r)) // [R1]
        else $error("SPI shifter moved without a serial clock edge.");
    AST_SPI_WRITE_FULL: assert property (spi_wr_go |-> spi_cnt_r == 4'hf ##1 // [R8]
        (reg_wr && reg_wdata == $past(spi_word_in) && reg_addr == $past(spi_addr_r)))
        else $error("SPI write committed without a complete word.");
    AST_SPI_ABORT: assert property (!cs_act |=> spi_cnt_r == 4'h0 && spi_st_r == dsrap_pkg::S_HDR) // [R8]
        else $error("Partial SPI word survived chip select release.");
    AST_ADDR_INC: assert property ((spi_wr_go || spi_rd_adv) && spi_addr_r != `FIFO_ADDR - 15'h1 // [R4]
        && spi_addr_r != `FIFO_ADDR && spi_addr_r != `LAST_ADDR
        |=> spi_addr_r == $past(spi_addr_r) + 15'h1)
        else $error("Address did not advance by one.");
    AST_ADDR_HOLD: assert property ((spi_wr_go || spi_rd_adv) // [R5]
        && (spi_addr_r == `FIFO_ADDR || spi_addr_r == `FIFO_ADDR - 15'h1 || spi_addr_r == `LAST_ADDR)
        |=> $stable(spi_addr_r))
        else $error("Address advanced at a held address.");
    AST_SPI_READ_MSB: assert property (spi_rd_req ##1 s_spi_fetch ##0 !spi_fifo ##1 spi_load_r[1] // [R10]
        |=> miso_r == $past(reg_rdata[15]))
        else $error("SPI read did not start with the MSB.");
    AST_FIFO_BYTE: assert property (spi_rd_adv |-> (spi_cnt_r == 4'h7) == spi_fifo) // [R6]
        else $error("FIFO read length is not one byte.");
    AST_I2C_ACK: assert property (i_ack_drive |=> sda_oe_r && i_ackph_r) // [R15]
        else $error("I2C byte was not acknowledged.");
    AST_I2C_STOP_FREE: assert property (i2c_stop |=> !sda_oe_r && i2c_st_r == dsrap_pkg::I_IDLE) // [R12]
        else $error("Data line still driven after stop.");
    AST_I2C_SHORT: assert property (i_byte_end && i2c_st_r == dsrap_pkg::I_REG_HI && !i_sh_r[7] // [R13]
        |=> i2c_st_r == dsrap_pkg::I_WR && i_addr_r[14:7] == 8'h00)
        else $error("Short register address decoded wrongly.");
    AST_I2C_PAIR: assert property (i_wr_go |-> i_have_hi_r ##1 s_i2c_commit) // [R16]
        else $error("I2C write committed without a byte pair.");
    AST_I2C_READ: assert property (i_rd_first |=> reg_rd && reg_addr == $past(i_addr_r)) // [R17]
        else $error("I2C read did not fetch the addressed register.");
endmodule
`default_nettype wire

// File: verification/host_model.sv
// Host model that masters the SPI and I2C pins of the register port.
`timescale 1ns/100ps
`default_nettype none
module host_model (
    output logic      sclk,     // SPI clock, idle low.
    output logic      spi_cs_b, // SPI select, active low.
    output logic      mosi,     // SPI data to device.
    input  wire logic miso,     // SPI data from device.
    output logic      scl,      // I2C clock.
    output logic      sda_low,  // High while host pulls SDA low.
    input  wire logic sda       // Resolved SDA level.
);
    // Idle pins: both clocks stand still outside frames.
    initial begin
        sclk = 1'b0;
        spi_cs_b = 1'b1;
        mosi = 1'b0;
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // One SPI frame, header then words, MSB first, mode 0.
    task automatic spi_frame(input logic [63:0] d, input int n, output logic [63:0] q);
        q = '0;
        spi_cs_b = 1'b0;
        #24;
        for (int i = n - 1; i >= 0; i--) begin
            mosi = d[i];
            #24 sclk = 1'b1;
            q[i] = miso;
            #24 sclk = 1'b0;
        end
        #24 spi_cs_b = 1'b1;
        mosi = ~mosi; // Released line shows the inverse of its last value.
        #100;
    endtask

    // Start or repeated start: SDA falls while SCL is high.
    task automatic i2c_start();
        sda_low = 1'b0;
        #24 scl = 1'b1;
        #24 sda_low = 1'b1;
        #24 scl = 1'b0;
        #24;
    endtask

    // Stop: SDA rises while SCL is high.
    task automatic i2c_stop();
        sda_low = 1'b1;
        #24 scl = 1'b1;
        #24 sda_low = 1'b0;
        #24;
    endtask

    // Nine bit times; a bit of one releases SDA so the device may drive it.
    task automatic i2c_byte(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            sda_low = ~d[i];
            #24 scl = 1'b1;
            q[i] = sda;
            #24 scl = 1'b0;
            #24;
        end
    endtask
endmodule
`default_nettype wire

// File: verification/tb.sv
// Self-checking bench of the dual serial register access port.
`timescale 1ns/100ps
`default_nettype none
`include "dsrap_defs.svh"
module tb;
    logic               sys_clk, rst_b, miso, miso_oe, sda_out, sda_oe, reg_wr, reg_rd;
    logic               sclk, spi_cs_b, mosi, scl, sda_low;
    logic [`ADDR_W-1:0] reg_addr;
    logic [`DATA_W-1:0] reg_wdata, reg_rdata;
    logic [15:0]        mem [0:1023];
    logic [7:0]         fifo_q [$];
    logic [30:0]        wr_q [$];
    logic [31:0]        seed = 32'd31276;
    int                 fails = 0;
    int                 total_checks = 0;
    wire                sda = ~(sda_oe | sda_low);

    dual_serial_register_access_port dut (.sys_clk(sys_clk), .rst_b(rst_b), .sclk(sclk), .spi_cs_b(spi_cs_b),
        .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    host_model host (.sclk(sclk), .spi_cs_b(spi_cs_b), .mosi(mosi), .miso(miso), .scl(scl), .sda_low(sda_low),
        .sda(sda));

    // Clock at 200 MHz.
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Xorshift source of random data.
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        if (fails == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Register model: writes are matched against the expected queue, reads answer next cycle.
    always @(posedge sys_clk) begin
        if (reg_wr) begin
            check(wr_q.size() > 0, 1'b1);
            if (wr_q.size() > 0) check({reg_addr, reg_wdata}, wr_q.pop_front());
            mem[reg_addr[9:0]] <= reg_wdata;
        end
        if (reg_rd) reg_rdata <= (reg_addr == `FIFO_ADDR) ? {8'h00, fifo_q.pop_front()} : mem[reg_addr[9:0]];
    end

    // Writes one I2C byte and expects the device to acknowledge it.
    task automatic w8(input logic [7:0] b);
        logic [8:0] q9;
        host.i2c_byte({b, 1'b1}, q9);
        check(q9[0], 1'b0);
    endtask

    // Main sequence.
    initial begin
        logic [63:0] q;
        logic [8:0]  q9;
        logic [14:0] a, b;
        logic [15:0] d0, d1;
        logic [31:0] rd;
        rst_b = 1'b0;
        reg_rdata = '0;
        for (int i = 0; i < 1024; i++) mem[i] = 16'(i * 40503);
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (420) @(posedge sys_clk);
        // Two whole SPI words then a partial one that must be dropped.
        b = 15'h100 + 15'(rnd() & 32'hff);
        d0 = 16'(rnd());
        d1 = 16'(rnd());
        wr_q.push_back({b, d0});
        wr_q.push_back({b + 15'h1, d1});
        host.spi_frame({8'h00, b, 1'b1, d0, d1, 8'ha5}, 56, q);
        check(wr_q.size(), 0);
        // Words at the address below the FIFO and at the last address stay put.
        for (int k = 0; k < 2; k++) begin
            a = k ? `LAST_ADDR : `FIFO_ADDR - 15'h1;
            d0 = 16'(rnd());
            d1 = 16'(rnd());
            wr_q.push_back({a, d0});
            wr_q.push_back({a, d1});
            host.spi_frame({16'h0, a, 1'b1, d0, d1}, 48, q);
        end
        check(wr_q.size(), 0);
        host.spi_frame({16'h0, b, 1'b0, 32'h0}, 48, q);
        check(q[31:0], {mem[b[9:0]], mem[10'(b + 15'h1)]});
        host.spi_frame({16'h0, `LAST_ADDR, 1'b0, 32'h0}, 48, q);
        check(q[31:0], {2{mem[10'h277]}});
        // FIFO bytes leave one at a time.
        for (int k = 0; k < 5; k++) fifo_q.push_back(8'(rnd()));
        rd = {8'h00, fifo_q[0], fifo_q[1], fifo_q[2]};
        host.spi_frame({24'h0, `FIFO_ADDR, 1'b0, 24'h0}, 40, q);
        check(q[23:0], rd[23:0]);
        // I2C short write of two words and an odd byte, then a long-address read of the two words at b.
        a = {8'h00, 2'b10, 5'(rnd())};
        d0 = 16'(rnd());
        d1 = 16'(rnd());
        wr_q.push_back({a, d0});
        wr_q.push_back({a + 15'h1, d1});
        host.i2c_start();
        w8({`I2C_DEV_ADDR, 1'b0});
        w8({1'b0, a[6:0]});
        w8(d0[15:8]);
        w8(d0[7:0]);
        w8(d1[15:8]);
        w8(d1[7:0]);
        w8(8'h5a);
        host.i2c_stop();
        #200;
        check(wr_q.size(), 0);
        host.i2c_start();
        w8({`I2C_DEV_ADDR, 1'b0});
        w8({1'b1, b[14:8]});
        w8(b[7:0]);
        host.i2c_start();
        w8({`I2C_DEV_ADDR, 1'b1});
        for (int k = 0; k < 4; k++) begin
            host.i2c_byte({8'hff, k == 3}, q9);
            rd = {rd[23:0], q9[8:1]};
        end
        host.i2c_stop();
        check(rd, {mem[b[9:0]], mem[10'(b + 15'h1)]});
        // A foreign slave address is not acknowledged.
        host.i2c_start();
        host.i2c_byte({`I2C_DEV_ADDR ^ 7'h01, 2'b01}, q9);
        host.i2c_stop();
        check(q9[0], 1'b1);
        check({miso_oe, sda_out, sda_oe}, 3'h0);
        complete_run();
    end

    // Watchdog well beyond the expected run time.
    initial begin
        #200000;
        fails++;
        complete_run();
    end
endmodule
`default_nettype wire
